// [rtl/cam_map.svh]
`ifndef CAM_MAP_SVH
`define CAM_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CAM_ADDR_CFG        8'h73
`define CAM_ADDR_MASK1      8'h74
`define CAM_ADDR_MASK2      8'h75

// ****************************************************************
// Reset values
// ****************************************************************
`define CAM_RESET_VAL       8'h00
`define CAM_UNMAPPED_VAL    8'h00

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define CAM_CFG_DETECT_EN   0
`define CAM_CFG_SEEN_LO     1
`define CAM_CFG_SEEN_HI     3
`define CAM_CFG_AVG_OFF     4
`define CAM_CFG_BYPASS      5
`define CAM_CFG_SINGLE      6
`define CAM_CFG_SHUTDOWN    7
`define CAM_CFG_WR_MASK     8'hf1

// ****************************************************************
// Mask register fields
// ****************************************************************
`define CAM_MASK1_GATE      7
`define CAM_STAT1_USED      8'h76
`define CAM_STAT2_USED      8'hfe
`define CAM_MASK2_FAN4      5

// ****************************************************************
// Channel select codes and counts
// ****************************************************************
`define CAM_SEL_CORE        3'h1
`define CAM_SEL_MAIN        3'h2
`define CAM_SEL_REMOTE_ONE  3'h5
`define CAM_SEL_LOCAL       3'h6
`define CAM_SEL_REMOTE_TWO  3'h7
`define CAM_FAN_COUNT       3

`endif

// [rtl/cam_pkg.sv]
`include "cam_map.svh"

package cam_pkg;

  // ****************************************************************
  // Register port from the serial management bus engine
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cam_regbus_s;

  typedef enum logic [2:0] {
    cam_ch_none,
    cam_ch_core,
    cam_ch_main,
    cam_ch_remote_one,
    cam_ch_local,
    cam_ch_remote_two
  } cam_channel_e;

  // ****************************************************************
  // Mode outputs to the measurement engine and fan drives
  // ****************************************************************
  typedef struct packed {
    logic         avg_off;
    logic         divider_bypass;
    logic         single_mode;
    cam_channel_e channel;
    logic         force_off;
    logic         off_level;
  } cam_mode_s;

  typedef struct packed {
    logic [`CAM_FAN_COUNT-1:0] s1;
    logic [`CAM_FAN_COUNT-1:0] s2;
    logic [`CAM_FAN_COUNT-1:0] s3;
    logic [`CAM_FAN_COUNT-1:0] stable;
  } cam_sync_s;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] rdata;
    cam_mode_s  mode;
    logic       alert_oe;
  } cam_state_s;

endpackage : cam_pkg

// [rtl/cam_sync.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cam_map.svh"

module cam_sync
  import cam_pkg::*;
(
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  // Pin side and settled level
  input  wire logic [`CAM_FAN_COUNT-1:0] pin_in,
  output logic      [`CAM_FAN_COUNT-1:0] stable_out
);

  cam_sync_s                 st;
  cam_sync_s                 next_st;
  logic [`CAM_FAN_COUNT-1:0] agree;

  // ****************************************************************
  // Settled level moves only once the last two stages agree
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `CAM_FAN_COUNT; g++)
    begin : g_agree
      assign agree[g] = (st.s2[g] == st.s3[g]);
    end
  endgenerate

  always_comb
  begin
    next_st        = st;
    next_st.s1     = pin_in;
    next_st.s2     = st.s1;
    next_st.s3     = st.s2;
    next_st.stable = (st.s3 & agree) | (st.stable & ~agree);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign stable_out = st.stable;

endmodule : cam_sync

`default_nettype wire

// [rtl/cam_alert.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cam_map.svh"

module cam_alert
  import cam_pkg::*;
(
  // Mask registers
  input  wire logic [7:0] mask1,
  input  wire logic [7:0] mask2,
  // Status conditions
  input  wire logic [7:0] stat1,
  input  wire logic [7:0] stat2,
  input  wire logic       overheat_on_pin,
  input  wire logic       overheat_timer_event,
  // Combined request
  output logic            alert_req
);

  logic [7:0] stat2_eff;
  logic       first_hit;
  logic       second_hit;
  logic       all_second_masked;
  logic       second_any;

  always_comb
  begin
    stat2_eff = stat2 & `CAM_STAT2_USED;
    // Shared bit follows whichever function the speed sense pin serves
    if (overheat_on_pin)
      stat2_eff[`CAM_MASK2_FAN4] = overheat_timer_event;
    first_hit  = |(stat1 & `CAM_STAT1_USED & ~mask1);
    second_hit = |(stat2_eff & ~mask2);
    all_second_masked = &(mask2 | ~`CAM_STAT2_USED);
    second_any = |stat2_eff;
    // Fully masked second status still alerts unless the gate bit is set
    alert_req = first_hit | second_hit
              | (all_second_masked & second_any & ~mask1[`CAM_MASK1_GATE]);
  end

endmodule : cam_alert

`default_nettype wire

// [rtl/cam_regs.sv]
// Overview of operation
// - Detect enable bit makes bits 3..1 report four-wire fan presence per channel.
// - Fan detect bits are read-only, each set when a four-wire fan is attached.
// - Averaging disable bit turns off measurement averaging for faster conversions.
// - Divider bypass bit removes attenuation from the core supply input.
// - Single-channel bit samples one input, chosen by a three-bit external field.
// - Codes 1,2,5,6,7 select core, main, remote one, local, remote two.
// - Shutdown bit forces every fan drive to its off level, set by polarity flip.
// - While lock is set the configuration register ignores writes.
// - First mask bits 1,2,4,5,6 suppress alerts for matching limit conditions.
// - With second mask all set, first mask bit 7 decides if second status still alerts.
// - Second mask bit 1 blocks overtemperature limit alerts.
// - Second mask bits 2,3,4 block fan one, two, three fault alerts.
// - Second mask bit 5 blocks fan four fault or overheat timer event.
// - Second mask bits 6,7 block diode faults on remote sensors one, two.
// - Power-on clears configuration and both mask registers to zero.
// - Alert reaches the shared pin only when the alert enable bit selects it.
`timescale 1ns/10ps
`default_nettype none
`include "cam_map.svh"

module cam_regs
  import cam_pkg::*;
(
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  // Register port from the serial management bus engine
  input  wire cam_pkg::cam_regbus_s      regbus,
  output logic      [7:0]                reg_rdata,
  // Settings held in neighbouring registers
  input  wire logic                      lock_active,
  input  wire logic [2:0]                channel_select_field,
  input  wire logic                      output_polarity_flip,
  input  wire logic                      alert_pin_enable,
  input  wire logic                      fourth_speed_sense_pin_is_overheat,
  // Fan presence sense pins
  input  wire logic [`CAM_FAN_COUNT-1:0] fan_four_wire_pin,
  // Status conditions from the monitoring logic
  input  wire logic [7:0]                first_status,
  input  wire logic [7:0]                second_status,
  input  wire logic                      overheat_timer_event,
  // Mode outputs
  output cam_pkg::cam_mode_s             mode,
  // Open-drain alert pin, low when driven
  output logic                           alert_pin_out,
  output logic                           alert_pin_oe
);

  cam_state_s                st;
  cam_state_s                next_st;
  logic [`CAM_FAN_COUNT-1:0] fan_seen;
  logic                      alert_req;
  logic [7:0]                cfg_view;

  // ****************************************************************
  // Fan presence pins come from outside the clock domain
  // ****************************************************************
  cam_sync u_sync
  (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .pin_in     (fan_four_wire_pin),
    .stable_out (fan_seen)
  );

  // ****************************************************************
  // Alert combination
  // ****************************************************************
  cam_alert u_alert
  (
    .mask1                (st.mask1),
    .mask2                (st.mask2),
    .stat1                (first_status),
    .stat2                (second_status),
    .overheat_on_pin      (fourth_speed_sense_pin_is_overheat),
    .overheat_timer_event (overheat_timer_event),
    .alert_req            (alert_req)
  );

  // ****************************************************************
  // Channel select decode
  // ****************************************************************
  function automatic cam_channel_e decode_channel(input logic [2:0] code);
    cam_channel_e ch;
    ch = cam_ch_none;
    if (code == `CAM_SEL_CORE)
      ch = cam_ch_core;
    else if (code == `CAM_SEL_MAIN)
      ch = cam_ch_main;
    else if (code == `CAM_SEL_REMOTE_ONE)
      ch = cam_ch_remote_one;
    else if (code == `CAM_SEL_LOCAL)
      ch = cam_ch_local;
    else if (code == `CAM_SEL_REMOTE_TWO)
      ch = cam_ch_remote_two;
    return ch;
  endfunction : decode_channel

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_st  = st;
    cfg_view = st.cfg;
    // Detect bits read zero while detection is off
    cfg_view[`CAM_CFG_SEEN_HI:`CAM_CFG_SEEN_LO] =
      st.cfg[`CAM_CFG_DETECT_EN] ? fan_seen : '0;

    if (regbus.wr)
    begin
      if (regbus.addr == `CAM_ADDR_CFG)
      begin
        if (!lock_active)
          next_st.cfg = regbus.wdata & `CAM_CFG_WR_MASK;
      end
      else if (regbus.addr == `CAM_ADDR_MASK1)
        next_st.mask1 = regbus.wdata;
      else if (regbus.addr == `CAM_ADDR_MASK2)
        next_st.mask2 = regbus.wdata;
    end

    if (regbus.rd)
    begin
      if (regbus.addr == `CAM_ADDR_CFG)
        next_st.rdata = cfg_view;
      else if (regbus.addr == `CAM_ADDR_MASK1)
        next_st.rdata = st.mask1;
      else if (regbus.addr == `CAM_ADDR_MASK2)
        next_st.rdata = st.mask2;
      else
        next_st.rdata = `CAM_UNMAPPED_VAL;
    end

    // Modes follow the stored register and the neighbouring settings one cycle later
    next_st.mode.avg_off        = st.cfg[`CAM_CFG_AVG_OFF];
    next_st.mode.divider_bypass = st.cfg[`CAM_CFG_BYPASS];
    next_st.mode.channel        = decode_channel(channel_select_field);
    // A reserved code leaves the converter scanning rather than sampling nothing
    next_st.mode.single_mode    = st.cfg[`CAM_CFG_SINGLE]
                                & (next_st.mode.channel != cam_ch_none);
    next_st.mode.force_off      = st.cfg[`CAM_CFG_SHUTDOWN];
    next_st.mode.off_level      = output_polarity_flip;

    next_st.alert_oe = alert_req & alert_pin_enable;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st       <= '0;
      st.cfg   <= `CAM_RESET_VAL;
      st.mask1 <= `CAM_RESET_VAL;
      st.mask2 <= `CAM_RESET_VAL;
    end
    else
      st <= next_st;
  end

  assign reg_rdata     = st.rdata;
  assign mode          = st.mode;
  // Open drain only ever pulls low; the level is tied to zero and only the enable is registered
  assign alert_pin_out = 1'b0;
  assign alert_pin_oe  = st.alert_oe;

endmodule : cam_regs

`default_nettype wire

// [testbench/cam_regs_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cam_map.svh"

module cam_regs_props
(
  // Clock and reset
  input wire logic                      sys_clk,
  input wire logic                      sys_rst,
  // Register port
  input wire cam_pkg::cam_regbus_s      regbus,
  input wire logic [7:0]                reg_rdata,
  // Neighbouring settings
  input wire logic                      lock_active,
  input wire logic [2:0]                channel_select_field,
  input wire logic                      output_polarity_flip,
  input wire logic                      alert_pin_enable,
  input wire logic                      fourth_speed_sense_pin_is_overheat,
  input wire logic [`CAM_FAN_COUNT-1:0] fan_four_wire_pin,
  // Status and outputs
  input wire logic [7:0]                first_status,
  input wire logic [7:0]                second_status,
  input wire logic                      overheat_timer_event,
  input wire cam_pkg::cam_mode_s        mode,
  input wire logic                      alert_pin_out,
  input wire logic                      alert_pin_oe
);
  import cam_pkg::*;
  localparam cam_channel_e chan_tab [8] = '{cam_ch_none, cam_ch_core, cam_ch_main,
    cam_ch_none, cam_ch_none, cam_ch_remote_one, cam_ch_local, cam_ch_remote_two};
  // ********
  // Shadow of the registers, built from the writes seen on the port
  // ********
  logic [7:0] scfg;
  logic [7:0] sm1;
  logic [7:0] sm2;
  logic [7:0] s2;
  logic       ex;
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      scfg <= 8'h00;
      sm1  <= 8'h00;
      sm2  <= 8'h00;
    end
    else if (regbus.wr)
    begin
      if (regbus.addr == `CAM_ADDR_CFG && !lock_active)
        scfg <= regbus.wdata & `CAM_CFG_WR_MASK;
      if (regbus.addr == `CAM_ADDR_MASK1)
        sm1 <= regbus.wdata;
      if (regbus.addr == `CAM_ADDR_MASK2)
        sm2 <= regbus.wdata;
    end
  always_comb
  begin
    s2 = second_status;
    if (fourth_speed_sense_pin_is_overheat)
      s2[5] = overheat_timer_event;
    ex = (|(first_status & 8'h76 & ~sm1)) || (|(s2 & 8'hfe & ~sm2))
      || (&sm2[7:1] && |s2[7:1] && !sm1[7]);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ********
  // Properties
  // ********
  a_alert_follow:
    assert property (!$past(sys_rst) |-> alert_pin_oe == $past(ex && alert_pin_enable))
    else $error("alert output differs from masked status");
  a_second_gate:
    assert property (sm1[7] && &sm2[7:1] && first_status == 8'h00 |=> !alert_pin_oe)
    else $error("second status alert not gated");
  a_pin_select:
    assert property ((!alert_pin_enable) [*2] |-> !alert_pin_oe)
    else $error("alert on pin while not selected");
  a_pin_drive_low:
    assert property (alert_pin_oe |-> alert_pin_out == 1'b0)
    else $error("alert pin not pulled low");
  a_mode_levels:
    assert property (!$past(sys_rst) |-> {mode.avg_off, mode.divider_bypass, mode.force_off,
      mode.off_level} == $past({scfg[4], scfg[5], scfg[7], output_polarity_flip}))
    else $error("mode level mismatch");
  a_single_mode:
    assert property (mode.single_mode == $past(scfg[6] && channel_select_field inside
      {3'h1, 3'h2, 3'h5, 3'h6, 3'h7}))
    else $error("single channel mode mismatch");
  a_channel_map:
    assert property ($past(scfg[6]) |-> mode.channel == $past(chan_tab[channel_select_field]))
    else $error("channel decode mismatch");
  a_cfg_readback:
    assert property (regbus.rd && regbus.addr == `CAM_ADDR_CFG |=>
      {reg_rdata[7:4], reg_rdata[0]} == $past({scfg[7:4], scfg[0]}))
    else $error("configuration read mismatch");
  a_detect_hidden:
    assert property (regbus.rd && regbus.addr == `CAM_ADDR_CFG && !scfg[0] |=>
      reg_rdata[3:1] == 3'h0)
    else $error("detect bits visible while disabled");
  c_alert: cover property (alert_pin_oe);
  c_single: cover property (mode.single_mode);
  c_locked_write: cover property (regbus.wr && lock_active && regbus.addr == `CAM_ADDR_CFG);
endmodule : cam_regs_props

bind cam_regs cam_regs_props chk (.*);

`default_nettype wire

// [testbench/cam_host.sv]
`timescale 1ns/10ps
`default_nettype none

module cam_host
(
  // Clock
  input  wire logic                 sys_clk,
  // Register port toward the device
  output var cam_pkg::cam_regbus_s  regbus,
  input  wire logic [7:0]           reg_rdata
);
  import cam_pkg::*;
  initial
    regbus = '0;
  // Released lines flip to their inverse so no stale value can pass as good
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regbus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge sys_clk);
    regbus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : put
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    put(1'b0, a, 8'h00);
    #1;
    d = reg_rdata;
  endtask : get
endmodule : cam_host

`default_nettype wire

// [testbench/config_and_alert_mask_regs_bench.sv]
`timescale 1ns/10ps
`default_nettype none

module config_and_alert_mask_regs_bench;
  import cam_pkg::*;
  logic        sys_clk, sys_rst, lock_active, output_polarity_flip, alert_pin_enable;
  logic        fourth_speed_sense_pin_is_overheat, overheat_timer_event;
  logic        alert_pin_out, alert_pin_oe;
  logic [2:0]  channel_select_field, fan_four_wire_pin;
  logic [7:0]  first_status, second_status, reg_rdata, got;
  cam_regbus_s regbus;
  cam_mode_s   mode;
  int          fails = 0;
  int          tests_run = 0;
  int          lims [5] = '{1, 2, 4, 5, 6};
  // Address, written value, value read back
  logic [23:0] rows [7] = '{24'h74ffff, 24'h745a5a, 24'h75ffff, 24'h75a5a5,
                            24'h73fef0, 24'h730e00, 24'h20ff00};
  // Channel codes 0 to 7 against the decoded channel of the mode output
  logic [2:0]  chan_exp [8] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h3, 3'h4, 3'h5};
  cam_host host
  (
    .sys_clk   (sys_clk),
    .regbus    (regbus),
    .reg_rdata (reg_rdata)
  );
  cam_regs dut
  (
    .sys_clk                            (sys_clk),
    .sys_rst                            (sys_rst),
    .regbus                             (regbus),
    .reg_rdata                          (reg_rdata),
    .lock_active                        (lock_active),
    .channel_select_field               (channel_select_field),
    .output_polarity_flip               (output_polarity_flip),
    .alert_pin_enable                   (alert_pin_enable),
    .fourth_speed_sense_pin_is_overheat (fourth_speed_sense_pin_is_overheat),
    .fan_four_wire_pin                  (fan_four_wire_pin),
    .first_status                       (first_status),
    .second_status                      (second_status),
    .overheat_timer_event               (overheat_timer_event),
    .mode                               (mode),
    .alert_pin_out                      (alert_pin_out),
    .alert_pin_oe                       (alert_pin_oe)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic alert_case(input logic [7:0] m1, m2, s1, s2, input logic exp);
    @(posedge sys_clk);
    first_status <= s1;
    second_status <= s2;
    host.put(1'b1, 8'h74, m1);
    host.put(1'b1, 8'h75, m2);
    repeat (2) @(posedge sys_clk);
    #1;
    check("alert", {7'h00, alert_pin_oe}, {7'h00, exp});
  endtask : alert_case
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    conclude();
  end
  initial
  begin
    {sys_rst, lock_active, output_polarity_flip, fourth_speed_sense_pin_is_overheat} = 4'h8;
    {alert_pin_enable, overheat_timer_event, channel_select_field, fan_four_wire_pin} = '0;
    {first_status, second_status} = '0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 8'h73; a < 8'h76; a++)
    begin
      host.get(a[7:0], got);
      check("reset value", got, 8'h00);
    end
    check("reset mode", mode, 8'h00);
    foreach (rows[k])
    begin
      host.put(1'b1, rows[k][23:16], rows[k][15:8]);
      host.get(rows[k][23:16], got);
      check("readback", got, rows[k][7:0]);
    end
    // Presence pins pass a synchroniser, so give them time to settle
    fan_four_wire_pin <= 3'b101;
    host.put(1'b1, 8'h73, 8'h01);
    repeat (6) @(posedge sys_clk);
    host.get(8'h73, got);
    check("detect", got, 8'h0b);
    lock_active <= 1'b1;
    host.put(1'b1, 8'h73, 8'hf0);
    host.get(8'h73, got);
    check("locked", got, 8'h0b);
    lock_active <= 1'b0;
    channel_select_field <= 3'h5;
    output_polarity_flip <= 1'b1;
    host.put(1'b1, 8'h73, 8'hf0);
    repeat (2) @(posedge sys_clk);
    #1;
    check("modes", mode, 8'hef);
    for (int c = 0; c < 8; c++)
    begin
      @(posedge sys_clk);
      channel_select_field <= c[2:0];
      repeat (2) @(posedge sys_clk);
      #1;
      check("single", {7'h00, mode.single_mode}, {7'h00, c inside {1, 2, 5, 6, 7}});
      check("channel", {5'h00, mode.channel}, {5'h00, chan_exp[c]});
    end
    host.put(1'b1, 8'h73, 8'h00);
    alert_pin_enable <= 1'b1;
    foreach (lims[k])
    begin
      alert_case(8'h00, 8'h00, 8'h01 << lims[k], 8'h00, 1'b1);
      alert_case(8'h01 << lims[k], 8'h00, 8'h01 << lims[k], 8'h00, 1'b0);
    end
    for (int i = 1; i < 8; i++)
    begin
      alert_case(8'h00, 8'h00, 8'h00, 8'h01 << i, 1'b1);
      alert_case(8'h00, 8'h01 << i, 8'h00, 8'h01 << i, 1'b0);
    end
    alert_case(8'h00, 8'hfe, 8'h00, 8'h04, 1'b1);
    alert_case(8'h80, 8'hfe, 8'h00, 8'h04, 1'b0);
    fourth_speed_sense_pin_is_overheat <= 1'b1;
    alert_case(8'h00, 8'h00, 8'h00, 8'h20, 1'b0);
    overheat_timer_event <= 1'b1;
    alert_case(8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    alert_case(8'h00, 8'h20, 8'h00, 8'h00, 1'b0);
    check("pin level", {7'h00, alert_pin_out}, 8'h00);
    alert_pin_enable <= 1'b0;
    alert_case(8'h00, 8'h00, 8'h02, 8'h00, 1'b0);
    // Load non-zero contents so the mid-run reset has something to clear
    host.put(1'b1, 8'h74, 8'hff);
    host.put(1'b1, 8'h73, 8'hf1);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 8'h73; a < 8'h75; a++)
    begin
      host.get(a[7:0], got);
      check("second reset", got, 8'h00);
    end
    conclude();
  end
endmodule : config_and_alert_mask_regs_bench

`default_nettype wire
